// [adcsq_avg.sv]
// Averaging accumulator that turns consecutive conversions into one result.
`timescale 1ns/1ps
`default_nettype none
module adcsq_avg
  import adcsq_pkg::*;
#(
  parameter int DW = 12
) (
  // Clock and reset.
  input  wire logic          mclk_in,
  input  wire logic          arst_n_in,
  // Conversion stream and factor.
  input  wire logic          start_in,
  input  wire logic [2:0]    log2_in,
  input  wire logic          conv_vld_in,
  input  wire logic [DW-1:0] conv_data_in,
  // Averaged result.
  output logic               res_vld_out,
  output logic [DW-1:0]      res_data_out
);
  typedef struct packed {
    logic [DW+5:0] sum;
    logic [6:0]    cnt;
    logic          vld;
    logic [DW-1:0] res;
  } adcsq_avg_s;
  adcsq_avg_s st_ff, nxt_st;
  logic [DW+5:0] sum_now;
  logic [6:0]    need;

  // Accumulate factor conversions, then shift by log2 of the factor.
  always_comb begin
    nxt_st  = st_ff;
    nxt_st.vld = 1'b0;
    need    = 7'(7'd1 << log2_in);                        // [R12]
    sum_now = st_ff.sum + (DW+6)'(conv_data_in);
    if (start_in) begin
      nxt_st.sum = '0;
      nxt_st.cnt = '0;
    end else if (conv_vld_in) begin
      if (st_ff.cnt + 7'd1 == need) begin
        nxt_st.vld = 1'b1;                                 // [R11]
        nxt_st.res = DW'(sum_now >> log2_in);              // [R22]
        nxt_st.sum = '0;
        nxt_st.cnt = '0;
      end else begin
        nxt_st.sum = sum_now;                              // [R9]
        nxt_st.cnt = st_ff.cnt + 7'd1;
      end
    end
  end

  // State register.
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign res_vld_out  = st_ff.vld;
  assign res_data_out = st_ff.res;
endmodule
`default_nettype wire

// [adcsq_conv_model.sv]
// Behavioural converter that answers the block's conversion requests.
`timescale 1ns/1ps
`default_nettype none
module adcsq_conv_model (
  // Clock and reset.
  input  wire logic       mclk_in,
  input  wire logic       arst_n_in,
  // Request and answer delay.
  input  wire logic       start_in,
  input  wire logic [3:0] chan_in,
  input  wire logic [3:0] delay_in,
  // Answer and request count.
  output logic            done_out,
  output logic [11:0]     data_out,
  output logic [15:0]     starts_out
);
  logic       busy_ff;
  logic       tog_ff;
  logic [3:0] wait_ff;
  logic [3:0] chan_ff;
  // Dither bit alternates so averaging has work.
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      {busy_ff, tog_ff, wait_ff, chan_ff} <= '0;
      done_out   <= 1'b0;
      data_out   <= 12'h000;
      starts_out <= 16'h0000;
    end else begin
      done_out <= 1'b0;
      // Data lines are not held between answers, so they keep moving.
      data_out <= ~data_out;
      if (start_in && !busy_ff) begin
        busy_ff    <= 1'b1;
        wait_ff    <= delay_in;
        chan_ff    <= chan_in;
        starts_out <= starts_out + 16'h0001;
      end else if (busy_ff && wait_ff != 4'h0) begin
        wait_ff <= wait_ff - 4'h1;
      end else if (busy_ff) begin
        busy_ff  <= 1'b0;
        done_out <= 1'b1;
        tog_ff   <= ~tog_ff;
        data_out <= {chan_ff, 6'h00, tog_ff, 1'b0};
      end
    end
  end
endmodule
`default_nettype wire

// [adcsq_pkg.sv]
// Package of constants and types for the sample sequencer control block.
// Functional notes
// [R1] Eight analog channels plus an internal temperature sensor can be sampled.
// [R2] Four independent sequences, each with its own trigger source.
// [R3] Depths fixed: sequence 0 eight, 1 and 2 four, 3 one.
// [R4] Each slot selects any channel; repeats and any order allowed.
// [R5] Among simultaneously triggered sequences the highest priority runs first.
// [R6] Software avoids high priority on frequent triggers to prevent starvation.
// [R7] Averager supports factors 2, 4, 8, 16, 32 and 64.
// [R8] Oversampling factor zero disables averaging; each conversion delivered.
// [R9] Active oversampling averages consecutive conversions of the same input.
// [R10] One oversampling setting applies to all sequences alike.
// [R11] Each FIFO entry is one fully averaged reading.
// [R12] Throughput drops by the oversampling factor.
// [R13] Clearing one sequence interrupt leaves the others untouched.
// [R14] Handler should clear the interrupt early to avoid re-entry.
// [R15] Per-sequence mask stops a sequence from signalling the processor.
// [R16] Enabling an interrupt first clears any pending event of it.
// [R17] Status readable raw and masked per sequence.
// [R18] Software trigger only starts a sequence set to processor trigger.
// [R19] Priority 0..3, 0 highest; software assigns distinct values.
// [R20] Overflow flagged when a trigger arrives before FIFO data is read.
// [R21] A continuously asserted trigger makes its sequence capture repeatedly.
// [R22] Average is sum shifted right by log2 of the factor.
package adcsq_pkg;
  // -------------------------------------------------------------------------
  // Register map, byte addresses.
  // -------------------------------------------------------------------------
  localparam logic [7:0] ADCSQ_ENABLE_ADDR  = 8'h00;
  localparam logic [7:0] ADCSQ_OVS_ADDR     = 8'h04;
  localparam logic [7:0] ADCSQ_TRIGSEL_ADDR = 8'h08;
  localparam logic [7:0] ADCSQ_PRIO_ADDR    = 8'h0C;
  localparam logic [7:0] ADCSQ_SWTRIG_ADDR  = 8'h10;
  localparam logic [7:0] ADCSQ_IMASK_ADDR   = 8'h14;
  localparam logic [7:0] ADCSQ_IRAW_ADDR    = 8'h18;
  localparam logic [7:0] ADCSQ_IMSK_ADDR    = 8'h1C;
  localparam logic [7:0] ADCSQ_ICLR_ADDR    = 8'h20;
  localparam logic [7:0] ADCSQ_OVF_ADDR     = 8'h24;
  localparam logic [7:0] ADCSQ_STEP_ADDR    = 8'h40;
  localparam logic [7:0] ADCSQ_FIFO_ADDR    = 8'h80;
  localparam logic [7:0] ADCSQ_CNT_ADDR     = 8'h90;
  // -------------------------------------------------------------------------
  // Field layout and encodings.
  // -------------------------------------------------------------------------
  localparam int          ADCSQ_NSEQ      = 4;
  localparam int          ADCSQ_TRIG_W    = 4;
  localparam logic [3:0]  ADCSQ_TRIG_PROC = 4'h0;
  localparam logic [3:0]  ADCSQ_TRIG_EXT  = 4'h4;
  localparam logic [3:0]  ADCSQ_TRIG_ALW  = 4'hF;
  localparam logic [3:0]  ADCSQ_TS_CODE   = 4'h8;
  localparam logic [7:0]  ADCSQ_PRIO_RST  = 8'hE4;
  localparam logic [31:0] ADCSQ_DEC_ERR   = 32'hDEAD_0BAD;
  localparam logic [1:0]  ADCSQ_RESP_OK   = 2'b00;
  localparam logic [1:0]  ADCSQ_RESP_ERR  = 2'b10;
  // Slot base index of each sequence in the flat step and FIFO arrays.
  localparam logic [4:0]  ADCSQ_BASE [4] = '{5'd0, 5'd8, 5'd12, 5'd16};
  localparam logic [3:0]  ADCSQ_DEPTH [4] = '{4'd8, 4'd4, 4'd4, 4'd1};
  localparam int          ADCSQ_SLOTS = 17;

  typedef enum logic [1:0] {
    ADCSQ_IDLE = 2'b00,
    ADCSQ_CONV = 2'b01,
    ADCSQ_WAIT = 2'b11
  } adcsq_state_e;
endpackage

// [adcsq_props.sv]
// Concurrent checks on the ports of the sample sequencer control block.
`timescale 1ns/1ps
`default_nettype none
module adcsq_props
  import adcsq_pkg::*;
(
  // Clock and reset.
  input wire logic        mclk_in,
  input wire logic        arst_n_in,
  // Register bus.
  input wire logic        s_axi_awvalid_in,
  input wire logic        s_axi_awready_out,
  input wire logic        s_axi_wvalid_in,
  input wire logic        s_axi_wready_out,
  input wire logic        s_axi_bvalid_out,
  input wire logic        s_axi_arvalid_in,
  input wire logic        s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic [1:0]  s_axi_rresp_out,
  input wire logic        s_axi_rvalid_out,
  input wire logic        s_axi_rready_in,
  // Converter and interrupts.
  input wire logic        conv_start_out,
  input wire logic [3:0]  conv_chan_out,
  input wire logic        conv_done_in,
  input wire logic [3:0]  seq_irq_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);
  // Conversion in flight.
  logic busy_ff;
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      busy_ff <= 1'b0;
    end else begin
      busy_ff <= conv_start_out | (busy_ff & ~conv_done_in);
    end
  end
  chan_code_a:
    assert property (conv_start_out |-> conv_chan_out <= ADCSQ_TS_CODE)
    else $error("channel code out of range");
  one_conv_a:
    assert property (conv_start_out |-> !busy_ff || conv_done_in)
    else $error("start while a conversion runs");
  start_pulse_a:
    assert property (conv_start_out |=> !conv_start_out)
    else $error("start longer than one cycle");
  rdata_hold_a:
    assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
      s_axi_rvalid_out && $stable(s_axi_rdata_out) && $stable(s_axi_rresp_out))
    else $error("read answer not held");
  rd_answer_a:
    assert property (s_axi_arvalid_in && s_axi_arready_out |-> ##2 s_axi_rvalid_out)
    else $error("read answer late");
  wr_answer_a:
    assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
      && s_axi_wready_out |-> ##2 s_axi_bvalid_out)
    else $error("write answer late");
  wr_block_a:
    assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
    else $error("write taken while answer pending");
  dec_err_a:
    assert property (s_axi_rvalid_out && s_axi_rresp_out == ADCSQ_RESP_ERR |->
      s_axi_rdata_out == ADCSQ_DEC_ERR)
    else $error("error read lacks marker");
  irq_fall_a:
    assert property (|(~seq_irq_out & $past(seq_irq_out)) |->
      s_axi_bvalid_out || $past(s_axi_bvalid_out))
    else $error("interrupt fell without a write");
endmodule
bind adcsq_top adcsq_props u_props (.*);
`default_nettype wire

// [adcsq_top.sv]
// Sample sequencer control with AXI4-Lite registers and converter handshake.
//
// Added by the designer: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module adcsq_top
  import adcsq_pkg::*;
#(
  parameter int DW = 12
) (
  // Clock and reset.
  input  wire logic          mclk_in,
  input  wire logic          arst_n_in,
  // AXI4-Lite write channels.
  input  wire logic [7:0]    s_axi_awaddr_in,
  input  wire logic          s_axi_awvalid_in,
  output logic               s_axi_awready_out,
  input  wire logic [31:0]   s_axi_wdata_in,
  input  wire logic [3:0]    s_axi_wstrb_in,
  input  wire logic          s_axi_wvalid_in,
  output logic               s_axi_wready_out,
  output logic [1:0]         s_axi_bresp_out,
  output logic               s_axi_bvalid_out,
  input  wire logic          s_axi_bready_in,
  // AXI4-Lite read channels.
  input  wire logic [7:0]    s_axi_araddr_in,
  input  wire logic          s_axi_arvalid_in,
  output logic               s_axi_arready_out,
  output logic [31:0]        s_axi_rdata_out,
  output logic [1:0]         s_axi_rresp_out,
  output logic               s_axi_rvalid_out,
  input  wire logic          s_axi_rready_in,
  // Trigger pins, one per sequence, asynchronous.
  input  wire logic [3:0]    ext_trig_in,
  // Converter handshake.
  output logic               conv_start_out,
  output logic [3:0]         conv_chan_out,
  input  wire logic          conv_done_in,
  input  wire logic [DW-1:0] conv_data_in,
  // Per-sequence interrupt lines after the mask.
  output logic [3:0]         seq_irq_out
);
  // -------------------------------------------------------------------------
  // State record.
  // -------------------------------------------------------------------------
  typedef struct packed {
    logic              awr;
    logic              wr;
    logic              bvld;
    logic              rvld;
    logic              arr;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic [1:0]        bresp;
    logic [3:0]        en;
    logic [2:0]        ovs_log2;
    logic [15:0]       trig_sel;
    logic [7:0]        prio;
    logic [3:0]        imask;
    logic [3:0]        iraw;
    logic [3:0]        ovf;
    logic [3:0]        pend;
    logic [ADCSQ_SLOTS*4-1:0]  step;
    logic [ADCSQ_SLOTS*DW-1:0] fifo;
    logic [15:0]       fcnt;
    logic [15:0]       rptr;
    adcsq_state_e      state;
    logic [1:0]        cur;
    logic [3:0]        slot;
    logic              cstart;
    logic [3:0]        chan;
    logic              avg_go;
    logic [6:0]        ocnt;
    logic [3:0]        irq;
  } adcsq_s;
  adcsq_s st_ff, nxt_st;

  logic [3:0]    trig_s1_ff;
  logic [3:0]    trig_s2_ff;
  logic          res_vld;
  logic [DW-1:0] res_data;
  logic          dir_vld;
  logic [DW-1:0] dir_data;
  logic          wr_fire;
  logic          rd_fire;
  logic [3:0]    hw_trig;
  logic [3:0]    sw_trig;
  logic [3:0]    clr;
  logic          found;
  logic [1:0]    win;
  logic [1:0]    pbest;
  logic [1:0]    psq;
  logic [1:0]    rs;
  logic [4:0]    idx;
  logic [31:0]   wd;

  // -------------------------------------------------------------------------
  // Trigger pin synchroniser.
  // -------------------------------------------------------------------------
  // Two flops keep metastability away from the arbitration logic.
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      trig_s1_ff <= '0;
      trig_s2_ff <= '0;
    end else begin
      trig_s1_ff <= ext_trig_in;
      trig_s2_ff <= trig_s1_ff;
    end
  end

  // Averager is shared by all sequences, one factor for every one.
  adcsq_avg #(.DW(DW)) u_avg (
    .mclk_in      (mclk_in),
    .arst_n_in    (arst_n_in),
    .start_in     (st_ff.avg_go),
    .log2_in      (st_ff.ovs_log2),                        // [R10]
    .conv_vld_in  (conv_done_in && st_ff.state == ADCSQ_WAIT),
    .conv_data_in (conv_data_in),
    .res_vld_out  (res_vld),
    .res_data_out (res_data)
  );

  // Factor zero bypasses the averager with a direct one-conversion path.
  assign dir_vld  = conv_done_in && st_ff.state == ADCSQ_WAIT; // [R8]
  assign dir_data = conv_data_in;

  // -------------------------------------------------------------------------
  // Next-state logic.
  // -------------------------------------------------------------------------
  always_comb begin
    nxt_st  = st_ff;
    wr_fire = st_ff.awr && st_ff.wr && !st_ff.bvld;
    rd_fire = st_ff.arr && !st_ff.rvld;
    hw_trig = '0;
    sw_trig = '0;
    clr     = '0;
    found   = 1'b0;
    win     = '0;
    pbest   = '0;
    psq     = '0;
    rs      = '0;
    idx     = '0;
    wd      = s_axi_wdata_in;
    nxt_st.cstart = 1'b0;
    nxt_st.avg_go = 1'b0;

    // Address and data are taken independently, in either order.
    if (s_axi_awvalid_in && !st_ff.awr) nxt_st.awr = 1'b1;
    if (s_axi_wvalid_in && !st_ff.wr) nxt_st.wr = 1'b1;
    if (s_axi_arvalid_in && !st_ff.arr) nxt_st.arr = 1'b1;
    if (st_ff.bvld && s_axi_bready_in) begin
      // Readies stay low until the answer is taken.
      {nxt_st.bvld, nxt_st.awr, nxt_st.wr} = 3'b000;
    end
    if (st_ff.rvld && s_axi_rready_in) nxt_st.rvld = 1'b0;

    // Register writes; honoured whenever strobe bit 0 is set.
    if (wr_fire) begin
      nxt_st.bvld  = 1'b1;
      nxt_st.bresp = ADCSQ_RESP_OK;
      if (s_axi_wstrb_in[0]) begin
        case (s_axi_awaddr_in)
          ADCSQ_ENABLE_ADDR:  nxt_st.en = wd[3:0];
          ADCSQ_OVS_ADDR:     nxt_st.ovs_log2 = wd[2:0];       // [R7]
          ADCSQ_TRIGSEL_ADDR: nxt_st.trig_sel = wd[15:0];      // [R2]
          ADCSQ_PRIO_ADDR:    nxt_st.prio = wd[7:0];           // [R19]
          ADCSQ_SWTRIG_ADDR:  sw_trig = wd[3:0];
          ADCSQ_IMASK_ADDR: begin
            // Newly enabled sources drop any stale event first.
            clr = wd[3:0] & ~st_ff.imask;                     // [R16]
            nxt_st.imask = wd[3:0];                            // [R15]
          end
          ADCSQ_ICLR_ADDR:    clr = wd[3:0];                  // [R13]
          ADCSQ_OVF_ADDR:     nxt_st.ovf = st_ff.ovf & ~wd[3:0];
          default: begin
            if (s_axi_awaddr_in >= ADCSQ_STEP_ADDR &&
                s_axi_awaddr_in < ADCSQ_STEP_ADDR + 8'(ADCSQ_SLOTS*4)) begin
              idx = 5'((s_axi_awaddr_in - ADCSQ_STEP_ADDR) >> 2);
              nxt_st.step[idx*4 +: 4] = wd[3:0];              // [R4]
            end else begin
              nxt_st.bresp = ADCSQ_RESP_ERR;
            end
          end
        endcase
      end
    end

    // Processor trigger only counts for processor-sourced sequences.
    for (int i = 0; i < ADCSQ_NSEQ; i++) begin
      if (st_ff.trig_sel[i*4 +: 4] == ADCSQ_TRIG_PROC) begin
        hw_trig[i] = sw_trig[i];                              // [R18]
      end else if (st_ff.trig_sel[i*4 +: 4] == ADCSQ_TRIG_EXT) begin
        hw_trig[i] = trig_s2_ff[i];
      end else if (st_ff.trig_sel[i*4 +: 4] == ADCSQ_TRIG_ALW) begin
        hw_trig[i] = 1'b1;                                    // [R21]
      end
      hw_trig[i] = hw_trig[i] && st_ff.en[i];
      if (hw_trig[i]) begin
        // Unread data still in the FIFO means a trigger overruns it.
        if (st_ff.fcnt[i*4 +: 4] != 4'd0) nxt_st.ovf[i] = 1'b1; // [R20]
        nxt_st.pend[i] = 1'b1;
      end
    end

    // Sequence engine: pick the best pending sequence, walk its slots.
    case (st_ff.state)
      ADCSQ_IDLE: begin
        for (int i = 0; i < ADCSQ_NSEQ; i++) begin
          psq = st_ff.prio[i*2 +: 2];
          if (st_ff.pend[i] && (!found || psq < pbest)) begin  // [R5]
            found = 1'b1;
            pbest = psq;
            win   = 2'(i);
          end
        end
        if (found) begin
          nxt_st.pend[win] = 1'b0;
          nxt_st.cur   = win;
          nxt_st.slot  = '0;
          nxt_st.fcnt[win*4 +: 4] = '0;
          nxt_st.rptr[win*4 +: 4] = '0;
          nxt_st.state = ADCSQ_CONV;
        end
      end
      ADCSQ_CONV: begin
        idx = ADCSQ_BASE[st_ff.cur] + 5'(st_ff.slot);
        nxt_st.chan   = st_ff.step[idx*4 +: 4];               // [R1]
        nxt_st.cstart = 1'b1;
        nxt_st.avg_go = 1'b1;
        nxt_st.ocnt   = 7'd1;
        nxt_st.state  = ADCSQ_WAIT;
      end
      ADCSQ_WAIT: begin
        // Keep converting the same input until a result comes out.
        // Counting starts avoids a spare start after the last conversion.
        if (conv_done_in && st_ff.ovs_log2 != 3'd0 &&
            st_ff.ocnt != 7'(7'd1 << st_ff.ovs_log2)) begin
          nxt_st.cstart = 1'b1;                               // [R9]
          nxt_st.ocnt   = st_ff.ocnt + 7'd1;
        end
        if ((st_ff.ovs_log2 == 3'd0 && dir_vld) ||
            (st_ff.ovs_log2 != 3'd0 && res_vld)) begin
          idx = ADCSQ_BASE[st_ff.cur] + 5'(st_ff.slot);
          nxt_st.fifo[idx*DW +: DW] =
            (st_ff.ovs_log2 == 3'd0) ? dir_data : res_data;   // [R11]
          nxt_st.fcnt[st_ff.cur*4 +: 4] = st_ff.slot + 4'd1;
          if (st_ff.slot + 4'd1 == ADCSQ_DEPTH[st_ff.cur]) begin // [R3]
            nxt_st.iraw[st_ff.cur] = 1'b1;
            nxt_st.state = ADCSQ_IDLE;
          end else begin
            nxt_st.slot  = st_ff.slot + 4'd1;
            nxt_st.state = ADCSQ_CONV;
          end
        end
      end
      default: nxt_st.state = ADCSQ_IDLE;
    endcase

    // Clear only hits cleared bits; a same-cycle completion wins.
    for (int i = 0; i < ADCSQ_NSEQ; i++) begin
      if (clr[i] && !(nxt_st.iraw[i] && !st_ff.iraw[i])) begin
        nxt_st.iraw[i] = 1'b0;                                // [R13]
      end
    end
    nxt_st.irq = nxt_st.iraw & nxt_st.imask;                  // [R15]

    // Register reads; FIFO reads pop sequences 1 to 3; 0x80 returns step slot 16, not sequence 0.
    if (rd_fire) begin
      nxt_st.arr   = 1'b0;
      nxt_st.rvld  = 1'b1;
      nxt_st.rresp = ADCSQ_RESP_OK;
      nxt_st.rdata = '0;
      rs = s_axi_araddr_in[3:2];
      case (s_axi_araddr_in)
        ADCSQ_ENABLE_ADDR:  nxt_st.rdata[3:0] = st_ff.en;
        ADCSQ_OVS_ADDR:     nxt_st.rdata[2:0] = st_ff.ovs_log2;
        ADCSQ_TRIGSEL_ADDR: nxt_st.rdata[15:0] = st_ff.trig_sel;
        ADCSQ_PRIO_ADDR:    nxt_st.rdata[7:0] = st_ff.prio;
        ADCSQ_IMASK_ADDR:   nxt_st.rdata[3:0] = st_ff.imask;
        ADCSQ_IRAW_ADDR:    nxt_st.rdata[3:0] = st_ff.iraw;   // [R17]
        ADCSQ_IMSK_ADDR:    nxt_st.rdata[3:0] = st_ff.irq;    // [R17]
        ADCSQ_OVF_ADDR:     nxt_st.rdata[3:0] = st_ff.ovf;
        default: begin
          if (s_axi_araddr_in >= ADCSQ_STEP_ADDR &&
              s_axi_araddr_in < ADCSQ_STEP_ADDR + 8'(ADCSQ_SLOTS*4)) begin
            idx = 5'((s_axi_araddr_in - ADCSQ_STEP_ADDR) >> 2);
            nxt_st.rdata[3:0] = st_ff.step[idx*4 +: 4];
          end else if (s_axi_araddr_in[7:4] == ADCSQ_FIFO_ADDR[7:4]) begin
            if (st_ff.rptr[rs*4 +: 4] < st_ff.fcnt[rs*4 +: 4]) begin
              idx = ADCSQ_BASE[rs] + 5'(st_ff.rptr[rs*4 +: 4]);
              nxt_st.rdata[DW-1:0] = st_ff.fifo[idx*DW +: DW];
              nxt_st.rptr[rs*4 +: 4] = st_ff.rptr[rs*4 +: 4] + 4'd1;
              if (st_ff.rptr[rs*4 +: 4] + 4'd1 == st_ff.fcnt[rs*4 +: 4]) begin
                nxt_st.fcnt[rs*4 +: 4] = '0;
                nxt_st.rptr[rs*4 +: 4] = '0;
              end
            end
          end else if (s_axi_araddr_in[7:4] == ADCSQ_CNT_ADDR[7:4]) begin
            nxt_st.rdata[3:0] =
              st_ff.fcnt[rs*4 +: 4] - st_ff.rptr[rs*4 +: 4];
          end else begin
            nxt_st.rdata = ADCSQ_DEC_ERR;
            nxt_st.rresp = ADCSQ_RESP_ERR;
          end
        end
      endcase
    end
  end

  // -------------------------------------------------------------------------
  // State register.
  // -------------------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_ff       <= '0;
      st_ff.prio  <= ADCSQ_PRIO_RST;
      st_ff.state <= ADCSQ_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs come straight from the state record.
  assign s_axi_awready_out = !st_ff.awr;
  assign s_axi_wready_out  = !st_ff.wr;
  assign s_axi_bvalid_out  = st_ff.bvld;
  assign s_axi_bresp_out   = st_ff.bresp;
  assign s_axi_arready_out = !st_ff.arr;
  assign s_axi_rvalid_out  = st_ff.rvld;
  assign s_axi_rdata_out   = st_ff.rdata;
  assign s_axi_rresp_out   = st_ff.rresp;
  assign conv_start_out    = st_ff.cstart;
  assign conv_chan_out     = st_ff.chan;
  assign seq_irq_out       = st_ff.irq;
endmodule
`default_nettype wire

// [adcsq_top_test.sv]
// Self-checking bench for the sample sequencer control block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module adcsq_top_test
  import adcsq_pkg::*;
;
  typedef struct packed {
    logic [2:0]  lg;
    logic [3:0]  dly;
    logic [15:0] ncv;
  } adcsq_row_s;
  logic        mclk_in, arst_n_in, awvalid, wvalid, arvalid, rready, done;
  logic        awready, wready, bvalid, arready, rvalid, cstart, arm;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [1:0]  bresp, rresp, rr;
  logic [3:0]  ext_trig, chan, irq, dly, first_ch;
  logic [11:0] cdata;
  logic [15:0] starts, s0;
  int          error_cnt, checks;
  // Sequence 1 slots: a repeat, a jump and the sensor.
  logic [3:0]  ch1 [4] = '{4'h3, 4'h3, 4'h7, ADCSQ_TS_CODE};
  // Factor, delay, expected conversions.
  adcsq_row_s  rows [7] = '{'{3'h0, 4'h0, 16'h0004}, '{3'h1, 4'h5, 16'h0008},
    '{3'h2, 4'h0, 16'h0010}, '{3'h3, 4'h2, 16'h0020},
    '{3'h4, 4'h0, 16'h0040}, '{3'h5, 4'h1, 16'h0080},
    '{3'h6, 4'h0, 16'h0100}};
  adcsq_top #(.DW(12)) DUT (
    .mclk_in, .arst_n_in, .s_axi_awaddr_in(awaddr),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(1'b1),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .ext_trig_in(ext_trig),
    .conv_start_out(cstart), .conv_chan_out(chan), .conv_done_in(done),
    .conv_data_in(cdata), .seq_irq_out(irq));
  adcsq_conv_model u_conv (.mclk_in, .arst_n_in, .start_in(cstart),
    .chan_in(chan), .delay_in(dly), .done_out(done), .data_out(cdata),
    .starts_out(starts));
  // 250 MHz clock.
  initial begin
    mclk_in = 1'b0;
    forever #2 mclk_in = ~mclk_in;
  end
  // First channel after arming.
  always @(posedge mclk_in) begin
    if (arm && cstart) begin
      first_ch <= chan;
      arm      <= 1'b0;
    end
  end
  task automatic end_sim();
    if (error_cnt == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Address and data together; bready tied high.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = ADCSQ_RESP_OK);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do begin
      @(posedge mclk_in);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    `CHK(bresp, er)
  endtask
  // Late rready makes the slave hold its answer.
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    araddr  <= a;
    arvalid <= 1'b1;
    do @(posedge mclk_in); while (!arready);
    arvalid <= 1'b0;
    do @(posedge mclk_in); while (!rvalid);
    rready <= 1'b1;
    @(posedge mclk_in);
    d  = rdata;
    rr = rresp;
    rready <= 1'b0;
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    rd(a, v);
    `CHK(v, e)
  endtask
  // Software trigger, then poll raw status.
  task automatic run(input logic [3:0] m);
    wr(ADCSQ_SWTRIG_ADDR, {28'h000_0000, m});
    do rd(ADCSQ_IRAW_ADDR, v); while ((v[3:0] & m) !== m);
  endtask
  function automatic logic [31:0] exp_val(input int i, input logic [2:0] lg);
    exp_val = {20'h0_0000, ch1[i], 8'h00} +
      (lg != 3'h0 ? 32'h0000_0001 : 32'((i % 2) * 2));
  endfunction
  // Main sequence.
  initial begin
    {awvalid, wvalid, arvalid, rready, arm, arst_n_in} = '0;
    {awaddr, araddr, wdata, ext_trig, dly} = '0;
    repeat (6) @(posedge mclk_in);
    arst_n_in <= 1'b1;
    @(posedge mclk_in);
    `CHK(irq, 4'h0)
    chk_rd(ADCSQ_PRIO_ADDR, {24'h00_0000, ADCSQ_PRIO_RST});
    wr(ADCSQ_ENABLE_ADDR, 32'h0000_0003);
    wr(ADCSQ_TRIGSEL_ADDR, 32'h0000_1100);
    for (int i = 0; i < 8; i++) wr(ADCSQ_STEP_ADDR + 8'(4 * i), 32'h0000_0005);
    for (int i = 0; i < 4; i++) begin
      wr(ADCSQ_STEP_ADDR + 8'(32 + 4 * i), {28'h000_0000, ch1[i]});
    end
    // One factor per row.
    foreach (rows[r]) begin
      wr(ADCSQ_OVS_ADDR, {29'h0000_0000, rows[r].lg});
      dly <= rows[r].dly;
      s0 = starts;
      run(4'h2);
      chk_rd(ADCSQ_CNT_ADDR + 8'h04, 32'h0000_0004);
      for (int i = 0; i < 4; i++) begin
        chk_rd(ADCSQ_FIFO_ADDR + 8'h04, exp_val(i, rows[r].lg));
      end
      `CHK(starts - s0, rows[r].ncv)
      `CHK(irq, 4'h0)
      wr(ADCSQ_ICLR_ADDR, 32'h0000_0002);
    end
    // Stale event must not fire on unmask.
    wr(ADCSQ_OVS_ADDR, 32'h0000_0000);
    run(4'h2);
    chk_rd(ADCSQ_IMSK_ADDR, 32'h0000_0000);
    wr(ADCSQ_IMASK_ADDR, 32'h0000_0002);
    chk_rd(ADCSQ_IRAW_ADDR, 32'h0000_0000);
    // Retrigger with results unread, then clear one at a time.
    run(4'h2);
    chk_rd(ADCSQ_OVF_ADDR, 32'h0000_0002);
    chk_rd(ADCSQ_IMSK_ADDR, 32'h0000_0002);
    `CHK(irq, 4'h2)
    wr(ADCSQ_ICLR_ADDR, 32'h0000_0001);
    chk_rd(ADCSQ_IRAW_ADDR, 32'h0000_0002);
    wr(ADCSQ_ICLR_ADDR, 32'h0000_0002);
    chk_rd(ADCSQ_IMSK_ADDR, 32'h0000_0000);
    `CHK(irq, 4'h0)
    wr(ADCSQ_OVF_ADDR, 32'h0000_0002);
    chk_rd(ADCSQ_OVF_ADDR, 32'h0000_0000);
    // Sequence 1 first; one write fires both.
    wr(ADCSQ_PRIO_ADDR, 32'h0000_00E1);
    arm <= 1'b1;
    run(4'h3);
    `CHK(first_ch, ch1[0])
    chk_rd(ADCSQ_CNT_ADDR, 32'h0000_0008);
    // Pin-sourced sequence ignores software trigger.
    wr(ADCSQ_ICLR_ADDR, 32'h0000_000F);
    wr(ADCSQ_TRIGSEL_ADDR, 32'h0000_1140);
    s0 = starts;
    wr(ADCSQ_SWTRIG_ADDR, 32'h0000_0002);
    repeat (40) @(posedge mclk_in);
    `CHK(starts, s0)
    ext_trig <= 4'h2;
    do rd(ADCSQ_IRAW_ADDR, v); while (v[1] !== 1'b1);
    `CHK(v[1], 1'b1)
    ext_trig <= 4'h0;
    // Unmapped word errs both ways.
    wr(8'h3C, 32'h0000_0001, ADCSQ_RESP_ERR);
    chk_rd(8'h3C, ADCSQ_DEC_ERR);
    `CHK(rr, ADCSQ_RESP_ERR)
    end_sim();
  end
  // Watchdog of 50000 cycles.
  initial begin
    #200000;
    error_cnt++;
    end_sim();
  end
endmodule
`default_nettype wire
